// ### msp_pkg.sv
// Package for the motor stall prevention supervisor: map, fields, defaults and timing
`default_nettype none
package msp_pkg;

	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam logic [7:0] ADDR_ACCEL_MODE = 8'h00;
	localparam logic [7:0] ADDR_ACCEL_LEVEL = 8'h04;
	localparam logic [7:0] ADDR_ACCEL_LOWER = 8'h08;
	localparam logic [7:0] ADDR_DECEL_MODE = 8'h0c;
	localparam logic [7:0] ADDR_RUN_MODE = 8'h10;
	localparam logic [7:0] ADDR_RUN_LEVEL = 8'h14;
	localparam logic [7:0] ADDR_TARGET_BUS = 8'h18;
	localparam logic [7:0] ADDR_EXC_GAIN = 8'h1c;
	localparam logic [7:0] ADDR_SETUP = 8'h20;
	localparam logic [7:0] ADDR_INPUT_VOLT = 8'h24;
	localparam logic [7:0] ADDR_BASE_FREQ = 8'h28;
	localparam logic [7:0] ADDR_STATUS = 8'h2c;

	// ************************************************************
	// Field positions of the setup register
	// ************************************************************
	localparam int SETUP_CLASS400_BIT = 0;
	localparam int SETUP_DUTY_NORMAL_BIT = 1;
	localparam int SETUP_DERATE_BIT = 2;

	// ************************************************************
	// Reset values and setting limits
	// ************************************************************
	localparam logic [1:0] ACCEL_MODE_RST = 2'h1;
	localparam logic [2:0] DECEL_MODE_RST = 3'h1;
	localparam logic [1:0] RUN_MODE_RST = 2'h1;
	localparam logic [7:0] LEVEL_LIMIT_HEAVY = 8'h96;
	localparam logic [7:0] LEVEL_LIMIT_NORMAL = 8'h78;
	localparam logic [7:0] LEVEL_LIMIT_DERATED = 8'h64;
	localparam logic [7:0] RUN_LEVEL_MIN = 8'h1e;
	localparam logic [7:0] ACCEL_LOWER_RST = 8'h32;
	localparam logic [7:0] ACCEL_LOWER_MAX = 8'h64;
	localparam logic [8:0] TARGET_BUS_MIN = 9'h096;
	localparam logic [8:0] TARGET_BUS_MAX = 9'h190;
	localparam logic [8:0] TARGET_BUS_RST = 9'h172;
	localparam logic [7:0] EXC_GAIN_RST = 8'h80;
	localparam logic [9:0] INPUT_VOLT_RST = 10'h0c8;
	localparam logic [15:0] BASE_FREQ_RST = 16'h1770;

	// ************************************************************
	// Fixed thresholds (current in %, voltage in V, frequency in 0.01 Hz)
	// ************************************************************
	localparam logic [15:0] ACCEL_SLOW_PCT = 16'h0055;
	localparam logic [15:0] PCT_SCALE = 16'h0064;
	localparam logic [9:0] STALL_V_200 = 10'h17c;
	localparam logic [9:0] STALL_V_400_HI = 10'h2f8;
	localparam logic [9:0] STALL_V_400_LO = 10'h294;
	localparam logic [9:0] INPUT_VOLT_SPLIT = 10'h190;
	localparam logic [15:0] RUN_MIN_FREQ = 16'h0258;
	localparam logic [7:0] RUN_HYST_PCT = 8'h02;
	localparam logic [7:0] RATE_FULL = 8'hff;
	localparam logic [7:0] RATE_REDUCED = 8'h80;
	localparam logic [7:0] RATE_STEP = 8'h10;
	localparam logic [3:0] DECEL_MULT_ONE = 4'h1;
	localparam logic [3:0] DECEL_MULT_MAX = 4'ha;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_HZ = 100_000_000;
	localparam int RUN_RELEASE_MS = 100;
	localparam int RUN_RELEASE_CYCLES = RUN_RELEASE_MS * (CLK_HZ / 1000);

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		RUN_IDLE = 3'b001,
		RUN_DECEL = 3'b010,
		RUN_RELEASE = 3'b100
	} msp_run_state_t;

	typedef struct packed {
		logic ramp_hold;
		logic [7:0] accel_scale;
		logic accel_min_time;
		logic [3:0] decel_mult;
		logic run_decel;
		logic run_decel_two;
		logic [8:0] flux_boost;
		logic brake_stall;
	} msp_ramp_cmd_t;

endpackage : msp_pkg
`default_nettype wire

// ### msp_stall_ctrl.sv
// Stall prevention supervisor: accel, decel and run stall logic with settings registers
`default_nettype none
module msp_stall_ctrl
	import msp_pkg::*;
#(
	parameter int RELEASE_CYCLES = RUN_RELEASE_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// Drive measurements and ramp state
	input wire logic sample_tick,
	input wire logic accel_active,
	input wire logic decel_active,
	input wire logic const_active,
	input wire logic ctrl_sensorless,
	input wire logic [7:0] out_current,
	input wire logic [9:0] bus_voltage,
	input wire logic [15:0] out_freq,
	// Ramp commands
	output msp_ramp_cmd_t ramp_cmd
);

	// ************************************************************
	// Functions
	// ************************************************************

	// Current strictly above pct percent of a level
	function automatic logic pct_over(input logic [7:0] cur, input logic [7:0] lvl, input logic [15:0] pct);
		pct_over = ({8'h00, cur} * PCT_SCALE) > ({8'h00, lvl} * pct);
	endfunction : pct_over

	// Upper setting limit from duty and carrier derating
	function automatic logic [7:0] level_limit(input logic duty_normal, input logic derate);
		if (derate) begin
			level_limit = LEVEL_LIMIT_DERATED;
		end else if (duty_normal) begin
			level_limit = LEVEL_LIMIT_NORMAL;
		end else begin
			level_limit = LEVEL_LIMIT_HEAVY;
		end
	endfunction : level_limit

	// ************************************************************
	// Settings registers
	// ************************************************************
	logic [1:0] accel_stall_mode_select;
	logic [7:0] accel_stall_current_level;
	logic [7:0] accel_stall_lower_limit;
	logic [2:0] decel_stall_mode_select;
	logic [1:0] run_stall_mode_select;
	logic [7:0] run_stall_current_level;
	logic [8:0] target_bus_level;
	logic [7:0] excitation_gain;
	logic [2:0] drive_setup;
	logic [9:0] input_voltage_setting;
	logic [15:0] base_freq;

	// Address decode and write validity
	wire logic wr_accel_mode = reg_write && reg_addr == ADDR_ACCEL_MODE;
	wire logic wr_accel_level = reg_write && reg_addr == ADDR_ACCEL_LEVEL;
	wire logic wr_accel_lower = reg_write && reg_addr == ADDR_ACCEL_LOWER;
	wire logic wr_decel_mode = reg_write && reg_addr == ADDR_DECEL_MODE;
	wire logic wr_run_mode = reg_write && reg_addr == ADDR_RUN_MODE;
	wire logic wr_run_level = reg_write && reg_addr == ADDR_RUN_LEVEL;
	wire logic wr_target = reg_write && reg_addr == ADDR_TARGET_BUS;
	wire logic wr_exc = reg_write && reg_addr == ADDR_EXC_GAIN;
	wire logic wr_setup = reg_write && reg_addr == ADDR_SETUP;
	wire logic wr_in_volt = reg_write && reg_addr == ADDR_INPUT_VOLT;
	wire logic wr_base = reg_write && reg_addr == ADDR_BASE_FREQ;
	wire logic [7:0] lvl_limit = level_limit(drive_setup[SETUP_DUTY_NORMAL_BIT], drive_setup[SETUP_DERATE_BIT]);
	wire logic accel_mode_ok = reg_wdata[31:2] == 30'h0 && reg_wdata[1:0] != 2'h3;
	wire logic accel_level_ok = reg_wdata[31:8] == 24'h0 && reg_wdata[7:0] <= lvl_limit;
	wire logic accel_lower_ok = reg_wdata[31:8] == 24'h0 && reg_wdata[7:0] <= ACCEL_LOWER_MAX;
	wire logic decel_mode_ok = reg_wdata[31:3] == 29'h0 && (reg_wdata[2:0] <= 3'h4 || reg_wdata[2:0] == 3'h7);
	wire logic run_mode_ok = reg_wdata[31:2] == 30'h0 && reg_wdata[1:0] != 2'h3;
	wire logic run_level_ok = reg_wdata[31:8] == 24'h0 && reg_wdata[7:0] >= RUN_LEVEL_MIN
		&& reg_wdata[7:0] <= lvl_limit;
	wire logic target_ok = reg_wdata[31:9] == 23'h0 && reg_wdata[8:0] >= TARGET_BUS_MIN
		&& reg_wdata[8:0] <= TARGET_BUS_MAX;

	// Settings writes; out-of-range mode, level, lower limit and target values leave the old setting; the other registers are written unchecked
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			accel_stall_mode_select <= ACCEL_MODE_RST;
			accel_stall_current_level <= LEVEL_LIMIT_HEAVY;
			accel_stall_lower_limit <= ACCEL_LOWER_RST;
			decel_stall_mode_select <= DECEL_MODE_RST;
			run_stall_mode_select <= RUN_MODE_RST;
			run_stall_current_level <= LEVEL_LIMIT_HEAVY;
			target_bus_level <= TARGET_BUS_RST;
			excitation_gain <= EXC_GAIN_RST;
			drive_setup <= 3'h0;
			input_voltage_setting <= INPUT_VOLT_RST;
			base_freq <= BASE_FREQ_RST;
		end else begin
			if (wr_accel_mode && accel_mode_ok) accel_stall_mode_select <= reg_wdata[1:0];
			if (wr_accel_level && accel_level_ok) accel_stall_current_level <= reg_wdata[7:0];
			if (wr_accel_lower && accel_lower_ok) accel_stall_lower_limit <= reg_wdata[7:0];
			if (wr_decel_mode && decel_mode_ok) decel_stall_mode_select <= reg_wdata[2:0];
			if (wr_run_mode && run_mode_ok) run_stall_mode_select <= reg_wdata[1:0];
			if (wr_run_level && run_level_ok) run_stall_current_level <= reg_wdata[7:0];
			if (wr_target && target_ok) target_bus_level <= reg_wdata[8:0];
			if (wr_exc) excitation_gain <= reg_wdata[7:0];
			if (wr_setup) drive_setup <= reg_wdata[2:0];
			if (wr_in_volt) input_voltage_setting <= reg_wdata[9:0];
			if (wr_base) base_freq <= reg_wdata[15:0];
		end
	end

	// ************************************************************
	// Derived levels
	// ************************************************************

	// Accel level shrinks with frequency in the constant power range
	wire logic const_power = out_freq > base_freq && base_freq != 16'h0;
	wire logic [23:0] scaled_prod = {16'h0, accel_stall_current_level} * {8'h0, base_freq};
	wire logic [23:0] scaled_level = const_power ? scaled_prod / {8'h0, out_freq} : {16'h0, accel_stall_current_level};
	wire logic [7:0] accel_level_eff = (scaled_level[7:0] < accel_stall_lower_limit) && const_power
		? accel_stall_lower_limit : scaled_level[7:0];

	// Decel stall bus voltage by class and input setting
	wire logic class400 = drive_setup[SETUP_CLASS400_BIT];
	wire logic [9:0] stall_voltage = !class400 ? STALL_V_200
		: (input_voltage_setting >= INPUT_VOLT_SPLIT ? STALL_V_400_HI : STALL_V_400_LO);
	wire logic [9:0] target_bus_eff = class400 ? {target_bus_level, 1'b0} : {1'b0, target_bus_level};

	// Comparisons
	wire logic accel_over = pct_over(out_current, accel_level_eff, PCT_SCALE);
	wire logic accel_near = pct_over(out_current, accel_level_eff, ACCEL_SLOW_PCT);
	wire logic bus_over = bus_voltage > stall_voltage;
	wire logic bus_above_target = bus_voltage > target_bus_eff;
	wire logic run_over = out_current > run_stall_current_level;
	wire logic run_below = out_current < run_stall_current_level - RUN_HYST_PCT;
	wire logic run_allowed = run_stall_mode_select != 2'h0 && !ctrl_sensorless
		&& out_freq > RUN_MIN_FREQ;

	// ************************************************************
	// Acceleration stall
	// ************************************************************
	logic accel_hold;
	logic [7:0] accel_scale;
	logic [7:0] next_accel_scale;
	logic next_accel_hold;

	// Next acceleration rate per mode
	always_comb begin
		next_accel_hold = 1'b0;
		next_accel_scale = RATE_FULL;
		if (accel_active) begin
			case (accel_stall_mode_select)
				2'h1: begin
					next_accel_hold = accel_over;
					next_accel_scale = accel_near ? RATE_REDUCED : RATE_FULL;
				end
				2'h2: begin
					if (accel_over || out_current == accel_level_eff) begin
						next_accel_scale = accel_scale > RATE_STEP ? accel_scale - RATE_STEP : 8'h00;
					end else begin
						next_accel_scale = accel_scale < RATE_FULL - RATE_STEP ? accel_scale + RATE_STEP : RATE_FULL;
					end
				end
				default: begin
					next_accel_scale = RATE_FULL;
				end
			endcase
		end
	end

	// Accel outputs update on the sample tick
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			accel_hold <= 1'b0;
			accel_scale <= RATE_FULL;
		end else if (sample_tick) begin
			accel_hold <= next_accel_hold;
			accel_scale <= next_accel_scale;
		end
	end

	// ************************************************************
	// Deceleration stall
	// ************************************************************
	logic decel_hold;
	logic [3:0] decel_mult;
	logic [8:0] flux_boost;
	logic next_decel_hold;
	logic [3:0] next_decel_mult;
	logic [8:0] next_flux_boost;

	// Next decel behaviour per mode
	always_comb begin
		next_decel_hold = 1'b0;
		next_decel_mult = DECEL_MULT_ONE;
		next_flux_boost = 9'h000;
		if (decel_active) begin
			case (decel_stall_mode_select)
				3'h1, 3'h3: begin
					next_decel_hold = bus_over;
				end
				3'h2: begin
					if (bus_above_target) begin
						next_decel_mult = decel_mult != 4'h0 ? decel_mult - 4'h1 : 4'h0;
					end else begin
						next_decel_mult = decel_mult < DECEL_MULT_MAX ? decel_mult + 4'h1 : DECEL_MULT_MAX;
					end
				end
				3'h4: begin
					next_flux_boost = {1'b0, excitation_gain};
				end
				3'h7: begin
					next_flux_boost = {1'b0, excitation_gain} + {2'b00, excitation_gain[7:1]};
				end
				default: begin
					next_decel_mult = DECEL_MULT_ONE;
				end
			endcase
		end
	end

	// Decel outputs update on the sample tick
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			decel_hold <= 1'b0;
			decel_mult <= DECEL_MULT_ONE;
			flux_boost <= 9'h000;
		end else if (sample_tick) begin
			decel_hold <= next_decel_hold;
			decel_mult <= next_decel_mult;
			flux_boost <= next_flux_boost;
		end
	end

	// ************************************************************
	// Run stall
	// ************************************************************
	msp_run_state_t run_state;
	msp_run_state_t next_run_state;
	logic [31:0] release_count;
	logic run_decel_two;
	wire logic release_done = release_count >= RELEASE_CYCLES - 1;

	// Run stall sequence: overload decel, then timed release
	always_comb begin
		next_run_state = run_state;
		case (run_state)
			RUN_IDLE: begin
				if (sample_tick && const_active && run_allowed && run_over) next_run_state = RUN_DECEL;
			end
			RUN_DECEL: begin
				if (!run_allowed) next_run_state = RUN_IDLE;
				else if (sample_tick && run_below) next_run_state = RUN_RELEASE;
			end
			RUN_RELEASE: begin
				if (!run_allowed) next_run_state = RUN_IDLE;
				else if (sample_tick && !run_below) next_run_state = RUN_DECEL;
				else if (release_done) next_run_state = RUN_IDLE;
			end
			default: begin
				next_run_state = RUN_IDLE;
			end
		endcase
	end

	// Run state, release timer and decel time selection
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			run_state <= RUN_IDLE;
			release_count <= 32'h0;
			run_decel_two <= 1'b0;
		end else begin
			run_state <= next_run_state;
			release_count <= (run_state == RUN_RELEASE && next_run_state == RUN_RELEASE) ? release_count + 32'h1 : 32'h0;
			if (run_state == RUN_IDLE) run_decel_two <= run_stall_mode_select == 2'h2;
		end
	end

	// ************************************************************
	// Ramp command and status
	// ************************************************************
	assign ramp_cmd.ramp_hold = accel_hold || decel_hold;
	assign ramp_cmd.accel_scale = accel_scale;
	assign ramp_cmd.accel_min_time = accel_stall_mode_select == 2'h2;
	assign ramp_cmd.decel_mult = decel_mult;
	assign ramp_cmd.run_decel = run_state != RUN_IDLE;
	assign ramp_cmd.run_decel_two = run_decel_two;
	assign ramp_cmd.flux_boost = flux_boost;
	assign ramp_cmd.brake_stall = decel_stall_mode_select == 3'h3;

	// Read selection
	logic [31:0] read_mux;
	always_comb begin
		case (reg_addr)
			ADDR_ACCEL_MODE: read_mux = {30'h0, accel_stall_mode_select};
			ADDR_ACCEL_LEVEL: read_mux = {24'h0, accel_stall_current_level};
			ADDR_ACCEL_LOWER: read_mux = {24'h0, accel_stall_lower_limit};
			ADDR_DECEL_MODE: read_mux = {29'h0, decel_stall_mode_select};
			ADDR_RUN_MODE: read_mux = {30'h0, run_stall_mode_select};
			ADDR_RUN_LEVEL: read_mux = {24'h0, run_stall_current_level};
			ADDR_TARGET_BUS: read_mux = {23'h0, target_bus_level};
			ADDR_EXC_GAIN: read_mux = {24'h0, excitation_gain};
			ADDR_SETUP: read_mux = {29'h0, drive_setup};
			ADDR_INPUT_VOLT: read_mux = {22'h0, input_voltage_setting};
			ADDR_BASE_FREQ: read_mux = {16'h0, base_freq};
			ADDR_STATUS: read_mux = {8'h0, accel_scale, decel_mult, run_state, accel_hold, decel_hold,
				run_decel_two, const_power, bus_over, 4'h0};
			default: read_mux = 32'h0;
		endcase
	end

	// Read data stands one cycle after the strobe only
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			reg_rdata <= 32'h0;
		end else begin
			reg_rdata <= reg_read ? read_mux : 32'h0;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_bad_decel_write;
		reg_write && reg_addr == ADDR_DECEL_MODE && !decel_mode_ok;
	endsequence

	sequence s_run_overload;
		run_state == RUN_IDLE && sample_tick && const_active && run_allowed && run_over;
	endsequence

	a_decel_mode_reject: assert property (s_bad_decel_write
		|=> decel_stall_mode_select == $past(decel_stall_mode_select))
		else $error("invalid decel mode accepted");
	a_accel_mode_range: assert property (accel_stall_mode_select != 2'h3)
		else $error("accel mode out of range");
	a_accel_hold_over: assert property (sample_tick && accel_active
		&& accel_stall_mode_select == 2'h1 && accel_over |=> ramp_cmd.ramp_hold)
		else $error("accel not held above level");
	a_decel_pause_bus: assert property (sample_tick && decel_active
		&& decel_stall_mode_select == 3'h1 && bus_over |=> ramp_cmd.ramp_hold)
		else $error("decel not paused on high bus");
	a_decel_mult_cap: assert property (ramp_cmd.decel_mult <= DECEL_MULT_MAX)
		else $error("decel faster than ten times");
	a_run_low_freq: assert property (run_state != RUN_IDLE
		&& (out_freq <= RUN_MIN_FREQ || ctrl_sensorless) |=> run_state == RUN_IDLE)
		else $error("run stall active when suppressed");
	a_run_overload_decel: assert property (s_run_overload |=> ramp_cmd.run_decel)
		else $error("no run decel on overload");
	a_release_timed: assert property ($fell(ramp_cmd.run_decel) && run_allowed |-> $past(release_done))
		else $error("run decel released early");
	a_flux_mode_seven: assert property (sample_tick && decel_active && decel_stall_mode_select == 3'h7
		&& excitation_gain > 8'h1 |=> ramp_cmd.flux_boost > {1'b0, excitation_gain})
		else $error("mode 7 boost not above mode 4");
	a_read_one_cycle: assert property (!reg_read |=> reg_rdata == 32'h0)
		else $error("read data outside its cycle");

endmodule : msp_stall_ctrl
`default_nettype wire

// ### msp_drive_model.sv
// Drive-side stand-in: ramp phases, measurements and control sample ticks
`default_nettype none
module msp_drive_model (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Operating point chosen by the bench
	input wire logic [2:0] ph,
	input wire logic sv,
	input wire logic [7:0] cu,
	input wire logic [9:0] bv,
	input wire logic [15:0] fq,
	// Toward the supervisor
	output logic tick,
	output logic [2:0] act,
	output logic sless,
	output logic [7:0] i_out,
	output logic [9:0] v_bus,
	output logic [15:0] f_out
);
	logic [2:0] cnt;
	// Tick every eight cycles, measurements latched like an ADC
	always_ff @(posedge clk) begin
		cnt <= reset_n ? cnt + 3'h1 : 3'h0;
		tick <= reset_n && cnt == 3'h7;
		{act, sless, i_out, v_bus, f_out} <= {ph, sv, cu, bv, fq};
	end
endmodule : msp_drive_model
`default_nettype wire

// ### tb_msp_stall_ctrl.sv
// Self-checking bench for the stall prevention supervisor
`default_nettype none
module tb_msp_stall_ctrl;
	import msp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic [2:0] ph = 3'h0;
	logic sv = 1'b0;
	logic [7:0] cu = 8'h00;
	logic [9:0] bv = 10'h000;
	logic [15:0] fq = 16'h0000;
	logic tick, sless;
	logic [2:0] act;
	logic [7:0] i_out;
	logic [9:0] v_bus;
	logic [15:0] f_out;
	msp_ramp_cmd_t rc;
	int err_count = 0;
	int tests_run = 0;
	logic [9:0] vt [6] = '{10'd381, 10'd380, 10'd761, 10'd760, 10'd661, 10'd660};

	msp_drive_model PM (.clk(clk), .reset_n(reset_n), .ph(ph), .sv(sv), .cu(cu), .bv(bv), .fq(fq),
		.tick(tick), .act(act), .sless(sless), .i_out(i_out), .v_bus(v_bus), .f_out(f_out));
	msp_stall_ctrl #(.RELEASE_CYCLES(50)) DUT (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.sample_tick(tick), .accel_active(act[2]), .decel_active(act[1]), .const_active(act[0]),
		.ctrl_sensorless(sless), .out_current(i_out), .bus_voltage(v_bus), .out_freq(f_out), .ramp_cmd(rc));

	// ************************************************************
	// Access and compare tasks
	// ************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask : rd
	// Set an operating point, then let a few ticks pass
	task automatic op(input logic [2:0] p, input logic [7:0] c, input logic [9:0] v, input logic [15:0] f, input int n);
		@(posedge clk);
		ph <= p;
		cu <= c;
		bv <= v;
		fq <= f;
		repeat (n) @(posedge clk);
		#1;
	endtask : op
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize

	// Clock and watchdog
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		#100us;
		err_count++;
		summarize();
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		#1 chk({rc.ramp_hold, rc.accel_scale, rc.decel_mult, rc.run_decel, rc.flux_boost}, {1'b0, 8'hff, 4'h1, 10'h0});
		rd(ADDR_ACCEL_MODE, 32'h1);
		rd(ADDR_ACCEL_LEVEL, 32'h96);
		rd(ADDR_DECEL_MODE, 32'h1);
		rd(ADDR_RUN_MODE, 32'h1);
		rd(ADDR_RUN_LEVEL, 32'h96);
		rd(ADDR_TARGET_BUS, 32'h172);
		rd(ADDR_STATUS, 32'h00ff1200);
		wr(ADDR_ACCEL_MODE, 32'h3);
		rd(ADDR_ACCEL_MODE, 32'h1);
		for (int m = 0; m < 8; m++) begin
			wr(ADDR_DECEL_MODE, 32'h1);
			wr(ADDR_DECEL_MODE, 32'(m));
			rd(ADDR_DECEL_MODE, (m == 5 || m == 6) ? 32'h1 : 32'(m));
		end
		wr(ADDR_RUN_MODE, 32'h3);
		rd(ADDR_RUN_MODE, 32'h1);
		wr(ADDR_RUN_LEVEL, 32'h1d);
		rd(ADDR_RUN_LEVEL, 32'h96);
		wr(ADDR_ACCEL_LEVEL, 32'h97);
		rd(ADDR_ACCEL_LEVEL, 32'h96);
		wr(ADDR_TARGET_BUS, 32'h191);
		rd(ADDR_TARGET_BUS, 32'h172);
		rd(8'h30, 32'h0);
		$display("register test done");
		wr(ADDR_ACCEL_LEVEL, 32'h64);
		op(3'h4, 8'd101, 10'd0, 16'd1000, 20);
		chk(rc.ramp_hold, 32'h1);
		op(3'h4, 8'd90, 10'd0, 16'd1000, 20);
		chk({rc.ramp_hold, rc.accel_scale}, {1'b0, 8'h80});
		op(3'h4, 8'd60, 10'd0, 16'd12000, 20);
		chk(rc.ramp_hold, 32'h1);
		op(3'h4, 8'd45, 10'd0, 16'd24000, 20);
		chk(rc.ramp_hold, 32'h0);
		wr(ADDR_ACCEL_MODE, 32'h0);
		op(3'h4, 8'd120, 10'd0, 16'd1000, 20);
		chk({rc.ramp_hold, rc.accel_scale}, {1'b0, 8'hff});
		wr(ADDR_ACCEL_MODE, 32'h2);
		chk(rc.accel_min_time, 32'h1);
		op(3'h4, 8'd120, 10'd0, 16'd1000, 200);
		chk(rc.accel_scale, 32'h0);
		op(3'h4, 8'd50, 10'd0, 16'd1000, 200);
		chk(rc.accel_scale, 32'hff);
		$display("accel test done");
		op(3'h2, 8'd0, 10'd0, 16'd1000, 20);
		chk(rc.flux_boost, 32'h0c0);
		wr(ADDR_DECEL_MODE, 32'h4);
		op(3'h2, 8'd0, 10'd0, 16'd1000, 20);
		chk(rc.flux_boost, 32'h080);
		wr(ADDR_DECEL_MODE, 32'h3);
		chk(rc.brake_stall, 32'h1);
		wr(ADDR_DECEL_MODE, 32'h0);
		op(3'h2, 8'd0, 10'd800, 16'd1000, 20);
		chk(rc.ramp_hold, 32'h0);
		wr(ADDR_DECEL_MODE, 32'h2);
		op(3'h2, 8'd0, 10'd0, 16'd1000, 200);
		chk(rc.decel_mult, 32'ha);
		op(3'h2, 8'd0, 10'd400, 16'd1000, 200);
		chk(rc.decel_mult, 32'h0);
		wr(ADDR_DECEL_MODE, 32'h1);
		for (int k = 0; k < 6; k++) begin
			wr(ADDR_SETUP, {31'h0, k > 1});
			wr(ADDR_INPUT_VOLT, k > 3 ? 32'd399 : 32'd400);
			op(3'h2, 8'd0, vt[k], 16'd1000, 20);
			chk(rc.ramp_hold, {31'h0, ~k[0]});
		end
		$display("decel test done");
		wr(ADDR_RUN_LEVEL, 32'h64);
		op(3'h1, 8'd101, 10'd0, 16'd1000, 20);
		chk({rc.run_decel, rc.run_decel_two}, 32'h2);
		op(3'h1, 8'd97, 10'd0, 16'd1000, 20);
		chk(rc.run_decel, 32'h1);
		op(3'h1, 8'd97, 10'd0, 16'd1000, 60);
		chk(rc.run_decel, 32'h0);
		op(3'h1, 8'd101, 10'd0, 16'd1000, 20);
		op(3'h1, 8'd98, 10'd0, 16'd1000, 100);
		chk(rc.run_decel, 32'h1);
		op(3'h1, 8'd90, 10'd0, 16'd1000, 80);
		chk(rc.run_decel, 32'h0);
		wr(ADDR_RUN_MODE, 32'h2);
		op(3'h1, 8'd101, 10'd0, 16'd1000, 20);
		chk({rc.run_decel, rc.run_decel_two}, 32'h3);
		op(3'h1, 8'd101, 10'd0, 16'd600, 20);
		chk(rc.run_decel, 32'h0);
		@(posedge clk) sv <= 1'b1;
		op(3'h1, 8'd101, 10'd0, 16'd1000, 20);
		chk(rc.run_decel, 32'h0);
		@(posedge clk) sv <= 1'b0;
		wr(ADDR_RUN_MODE, 32'h0);
		op(3'h1, 8'd101, 10'd0, 16'd1000, 20);
		chk(rc.run_decel, 32'h0);
		$display("run test done");
		summarize();
	end
endmodule : tb_msp_stall_ctrl
`default_nettype wire
